// ---- alarm_pkg.sv ----
package alarm_pkg;
  localparam logic [7:0] SECOND_ADDR  = 8'h10;
  localparam logic [7:0] MINUTE_ADDR  = 8'h11;
  localparam logic [7:0] HOUR_ADDR    = 8'h12;
  localparam logic [7:0] DAY_ADDR     = 8'h13;
  localparam logic [7:0] WEEKDAY_ADDR = 8'h14;
  localparam logic [7:0] MONTH_ADDR   = 8'h15;
  localparam int         ENABLE_BIT   = 7;
  localparam logic [7:0] RESET_VALUE  = 8'h00;
  localparam logic [7:0] SECOND_MASK  = 8'h7F;
  localparam logic [7:0] MINUTE_MASK  = 8'h7F;
  localparam logic [7:0] HOUR_MASK    = 8'h3F;
  localparam logic [7:0] DAY_MASK     = 8'h3F;
  localparam logic [7:0] WEEKDAY_MASK = 8'h07;
  localparam logic [7:0] MONTH_MASK   = 8'h1F;
  localparam int         FIELD_COUNT  = 6;
  localparam int         ADDR_W       = 8;
endpackage

// ---- calendar_alarm_compare_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module calendar_alarm_compare_regs
  import alarm_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      wr_en,
  input  wire logic                      rd_en,
  input  wire logic [alarm_pkg::ADDR_W-1:0] addr,
  input  wire logic [7:0]                wr_data,
  output logic      [7:0]                rd_data,
  output logic                           rd_valid,
  input  wire logic                      second_tick,
  input  wire logic [7:0]                now_second,
  input  wire logic [7:0]                now_minute,
  input  wire logic [7:0]                now_hour,
  input  wire logic [7:0]                now_day,
  input  wire logic [7:0]                now_weekday,
  input  wire logic [7:0]                now_month,
  input  wire logic                      alarm_irq_enable,
  input  wire logic                      flag_clear,
  output logic                           alarm_hit_flag,
  output logic                           int_n
);
  import alarm_pkg::*;

  logic [7:0] regs [FIELD_COUNT];
  logic [7:0] now_v [FIELD_COUNT];
  logic [7:0] mask_v [FIELD_COUNT];
  logic [FIELD_COUNT-1:0] field_ok;
  logic [FIELD_COUNT-1:0] hit_sel;
  wire        any_enabled;
  wire        all_match;
  logic       prev_match;
  wire        new_match;
  wire        set_flag;
  wire        in_range;
  wire  [2:0] idx;
  wire  [7:0] next_rd_data;

  assign now_v[0]  = now_second;
  assign now_v[1]  = now_minute;
  assign now_v[2]  = now_hour;
  assign now_v[3]  = now_day;
  assign now_v[4]  = now_weekday;
  assign now_v[5]  = now_month;
  assign mask_v[0] = SECOND_MASK;
  assign mask_v[1] = MINUTE_MASK;
  assign mask_v[2] = HOUR_MASK;
  assign mask_v[3] = DAY_MASK;
  assign mask_v[4] = WEEKDAY_MASK;
  assign mask_v[5] = MONTH_MASK;

  // Register index from address; weekday follows day directly
  assign in_range = (addr >= SECOND_ADDR) && (addr <= MONTH_ADDR);
  assign idx      = in_range ? 3'(addr - SECOND_ADDR) : 3'h0;
  assign next_rd_data = in_range ? regs[idx] : 8'h00;

  genvar g;
  generate
    for (g = 0; g < FIELD_COUNT; g++)
    begin : field
      wire en = regs[g][ENABLE_BIT];
      // Hour bit 5 compared as twenty digit or PM alike
      assign field_ok[g] = !en ||
        ((regs[g] & mask_v[g]) == (now_v[g] & mask_v[g]));
      assign hit_sel[g] = en;

      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          regs[g] <= RESET_VALUE;
        else if (wr_en && in_range && idx == 3'(g))
          regs[g] <= wr_data & (mask_v[g] | 8'h80);
      end
    end
  endgenerate

  assign any_enabled = |hit_sel;
  assign all_match   = any_enabled && (&field_ok);
  assign new_match   = second_tick && all_match && !prev_match;
  assign set_flag    = new_match && alarm_irq_enable;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      prev_match <= 1'b0;
    else if (second_tick)
      prev_match <= all_match;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      alarm_hit_flag <= 1'b0;
      int_n          <= 1'b1;
    end
    else if (set_flag)
    begin
      alarm_hit_flag <= 1'b1;
      int_n          <= 1'b0;
    end
    else if (flag_clear)
    begin
      alarm_hit_flag <= 1'b0;
      int_n          <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_data  <= rd_en ? next_rd_data : 8'h00;
      rd_valid <= rd_en;
    end
  end

  flag_set_a: assert property (@(posedge clk) disable iff (!nrst)
    set_flag |=> alarm_hit_flag && !int_n) else $error("flag not set on match");
  int_follows_a: assert property (@(posedge clk) disable iff (!nrst)
    int_n == !alarm_hit_flag) else $error("interrupt and flag disagree");
  no_irq_en_a: assert property (@(posedge clk) disable iff (!nrst)
    !alarm_hit_flag && !alarm_irq_enable && !flag_clear |=> !alarm_hit_flag)
    else $error("flag set with irq disabled");
  once_per_a: assert property (@(posedge clk) disable iff (!nrst)
    second_tick && prev_match |-> !new_match) else $error("repeat match event");
  tick_only_a: assert property (@(posedge clk) disable iff (!nrst)
    !second_tick |-> !new_match) else $error("match off tick");
  disabled_ign_a: assert property (@(posedge clk) disable iff (!nrst)
    !regs[0][ENABLE_BIT] |-> field_ok[0]) else $error("disabled field counted");
  sec_cmp_a: assert property (@(posedge clk) disable iff (!nrst)
    regs[0][ENABLE_BIT] && regs[0][6:0] != now_second[6:0] |-> !all_match)
    else $error("seconds mismatch ignored");
  week_store_a: assert property (@(posedge clk) disable iff (!nrst)
    wr_en && addr == WEEKDAY_ADDR |=> regs[4] == ($past(wr_data) & 8'h87))
    else $error("weekday write wrong");
  readback_a: assert property (@(posedge clk) disable iff (!nrst)
    rd_en && addr == MONTH_ADDR && !wr_en |=> rd_data == regs[5])
    else $error("month readback wrong");
endmodule
`default_nettype wire

// ---- time_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module time_source (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        fire,
  input  wire logic [47:0] t_in,
  output logic             tick,
  output logic      [47:0] now
);
  // One tick per counter update, counters change with it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tick <= 1'b0;
      now  <= '0;
    end
    else
    begin
      tick <= fire;
      if (fire)
        now <= t_in;
    end
  end
endmodule
`default_nettype wire

// ---- test_calendar_alarm_compare_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_calendar_alarm_compare_regs;
  import alarm_pkg::*;
  logic clk, nrst, wr_en, rd_en, rd_valid, fire, tick, irq_en, clr, flag, int_n;
  logic [7:0]  addr, wr_data, rd_data;
  logic [47:0] t_in, now;
  int          fails, n_tests;
  calendar_alarm_compare_regs i_dut (.clk, .nrst, .wr_en, .rd_en, .addr, .wr_data,
    .rd_data, .rd_valid, .second_tick(tick), .now_second(now[47:40]),
    .now_minute(now[39:32]), .now_hour(now[31:24]), .now_day(now[23:16]),
    .now_weekday(now[15:8]), .now_month(now[7:0]), .alarm_irq_enable(irq_en),
    .flag_clear(clr), .alarm_hit_flag(flag), .int_n);
  time_source i_src (.clk, .nrst, .fire, .t_in, .tick, .now);
  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic step;
    @(posedge clk);
    #5;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a; wr_data = d; wr_en = 1; step; wr_en = 0; step;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr = a; rd_en = 1; step; rd_en = 0;
    chk("rd_data", e, rd_data);
    chk("rd_valid", 8'h01, {7'h00, rd_valid});
    step;
  endtask
  task automatic tk(input logic [7:0] s, input logic e);
    t_in = {s, 40'h9999999999}; fire = 1; step; fire = 0; step;
    chk("flag", {7'h00, e}, {7'h00, flag});
    chk("int_n", {7'h00, !e}, {7'h00, int_n});
  endtask
  task automatic regs_scenario;
    logic [7:0] m [6];
    m = '{SECOND_MASK, MINUTE_MASK, HOUR_MASK, DAY_MASK, WEEKDAY_MASK, MONTH_MASK};
    for (int i = 0; i < 6; i++) wr(8'h10 + 8'(i), 8'hFF);
    for (int i = 0; i < 6; i++) rd(8'h10 + 8'(i), 8'h80 | m[i]);
    rd(8'h16, 8'h00);
  endtask
  task automatic alarm_scenario;
    for (int i = 1; i < 6; i++) wr(8'h10 + 8'(i), 8'h00);
    wr(SECOND_ADDR, 8'hB0);
    irq_en = 1;
    tk(8'h30, 1);
    clr = 1; step; clr = 0;
    tk(8'h30, 0);
    tk(8'h31, 0);
    tk(8'h30, 1);
    clr = 1; step; clr = 0; irq_en = 0;
    tk(8'h31, 0);
    tk(8'h30, 0);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    {nrst, wr_en, rd_en, fire, irq_en, clr, addr, wr_data, t_in} = '0;
    repeat (2) @(posedge clk);
    #5 nrst = 1;
    rd(SECOND_ADDR, RESET_VALUE);
    regs_scenario();
    alarm_scenario();
    complete_run();
  end
  initial
  begin
    #1ms fails++;
    complete_run();
  end
endmodule
`default_nettype wire
